// file: hdl/gpio_port_pin_access.sv
// APB register block for general-purpose I/O port 0.
// Assumes pad levels are asynchronous and pass a two-flop synchroniser;
// analog and function selects come from the pin configuration logic.
`timescale 1ns/100ps
`include "gpio_port_params.svh"
module gpio_port_pin_access
	import gpio_port_pkg::*;
#(
	parameter int NPINS = `GP_NPINS,
	parameter logic [`GP_NPINS-1:0] PRESENT_MASK = ~`GP_ABSENT_MASK
)
(
	input wire logic pclk, // APB clock, 10 MHz
	input wire logic presetn, // Asynchronous reset, active low
	input wire logic psel, // Slave select
	input wire logic penable, // Access phase
	input wire logic pwrite, // Write when high
	input wire logic [13:0] paddr, // Byte address within the block
	input wire logic [31:0] pwdata, // Write data
	input wire logic [3:0] pstrb, // Write byte strobes
	output logic [31:0] prdata, // Read data, registered
	output logic pready, // Access complete, registered
	output logic pslverr, // Error on unmapped address
	input wire logic [NPINS-1:0] pin_level, // Sensed pad levels
	input wire logic [NPINS-1:0] pin_analog, // Pin set to analog I/O
	input wire logic [NPINS-1:0] pin_gpio_sel, // Pin assigned to GPIO
	output logic [NPINS-1:0] pad_out, // Pad output values
	output logic [NPINS-1:0] pad_oe_n // Pad output enable, low drives
);
	// Refuse any pin count other than the one the fixed register layout holds
	if (NPINS != `GP_NPINS)
	begin : g_bad_npins
		$error("NPINS must match the register layout");
	end

	logic [NPINS-1:0] sync1_r;
	logic [NPINS-1:0] sync2_r;
	logic [NPINS-1:0] dir_r;
	logic [NPINS-1:0] mask_r;
	logic [NPINS-1:0] out_r;
	logic [NPINS-1:0] out_nxt;
	logic [NPINS-1:0] dir_nxt;
	logic [NPINS-1:0] state_w;
	logic [NPINS-1:0] wr_bits;
	logic [NPINS-1:0] wr_en;
	logic [31:0] bmask;
	logic [31:0] wdm;
	logic [31:0] rd_nxt;
	logic [13:0] aw;
	logic in_byte;
	logic in_word;
	logic mapped;
	logic acc;
	logic wr;
	logic [4:0] wsel;
	logic [4:0] bsel;
	apb_phase_e phase_r;

	// Two flops ahead of any logic; pads are asynchronous to pclk
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync1_r <= '0;
			sync2_r <= '0;
		end
		else
		begin
			sync1_r <= pin_level;
			sync2_r <= sync1_r;
		end
	end

	// RULE2 RULE14 RULE15 readable state
	assign state_w = sync2_r & ~pin_analog & PRESENT_MASK;

	// Byte-lane mask of the write strobes
	always_comb
	begin
		bmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
		wdm = pwdata & bmask;
	end

	// RULE9 address decode, word-aligned base for every register, byte pins included
	assign aw = {paddr[13:2], 2'b00};
	assign in_byte = (aw <= ((`GP_BYTE_LAST >> 2) << 2));
	assign in_word = (aw >= `GP_WORD_BASE) && (aw <= `GP_WORD_LAST);
	assign wsel = 5'((aw - `GP_WORD_BASE) >> 2);
	assign bsel = 5'(aw);
	assign mapped = in_byte || in_word || (aw == `GP_OFS_DIR) ||
		(aw == `GP_OFS_MASK) || (aw == `GP_OFS_PIN) || (aw == `GP_OFS_MPIN) ||
		(aw == `GP_OFS_SET) || (aw == `GP_OFS_CLR) || (aw == `GP_OFS_NOT) ||
		(aw == `GP_OFS_DIRSET) || (aw == `GP_OFS_DIRCLR) || (aw == `GP_OFS_DIRNOT);
	// One-wait-state slave: acts in the cycle after setup, then pready rises
	assign acc = psel && penable && (phase_r == ACC_SETUP);
	assign wr = acc && pwrite && mapped;

	// Per-pin write data from byte-pin and word-pin lanes
	genvar g;
	generate
		for (g = 0; g < NPINS; g++)
		begin : g_pin
			// RULE3 RULE4 RULE5 byte lane bit 0
			assign wr_bits[g] = in_byte ? pwdata[8*(g%4)] : (in_word ? (wdm != '0) : 1'b0);
			// RULE7 word pin any nonzero
			assign wr_en[g] = in_byte ? ((aw[4:2] == 3'(g/4)) && pstrb[g%4]) :
				(in_word ? ((wsel == 5'(g)) && (pstrb != '0)) : 1'b0);
		end
	endgenerate

	// Next output bits for each output-changing register
	always_comb
	begin
		out_nxt = out_r;
		if (wr)
		begin
			if (in_byte || in_word)
				out_nxt = (out_r & ~wr_en) | (wr_bits & wr_en);
			// RULE18 whole port ignores mask
			else if (aw == `GP_OFS_PIN)
				out_nxt = (out_r & ~bmask[NPINS-1:0]) | (pwdata[NPINS-1:0] & bmask[NPINS-1:0]);
			// RULE17 masked port write
			else if (aw == `GP_OFS_MPIN)
				out_nxt = (out_r & ~(bmask[NPINS-1:0] & ~mask_r)) |
					(pwdata[NPINS-1:0] & bmask[NPINS-1:0] & ~mask_r);
			// RULE12 set writes ones
			else if (aw == `GP_OFS_SET)
				out_nxt = out_r | wdm[NPINS-1:0];
			// RULE19 clear writes ones
			else if (aw == `GP_OFS_CLR)
				out_nxt = out_r & ~wdm[NPINS-1:0];
			// RULE20 toggle writes ones
			else if (aw == `GP_OFS_NOT)
				out_nxt = out_r ^ wdm[NPINS-1:0];
		end
		out_nxt = out_nxt & PRESENT_MASK;
	end

	// RULE13 direction aliases; RULE10 plain direction write
	always_comb
	begin
		dir_nxt = dir_r;
		if (wr)
		begin
			if (aw == `GP_OFS_DIR)
				dir_nxt = (dir_r & ~bmask[NPINS-1:0]) | wdm[NPINS-1:0];
			else if (aw == `GP_OFS_DIRSET)
				dir_nxt = dir_r | wdm[NPINS-1:0];
			else if (aw == `GP_OFS_DIRCLR)
				dir_nxt = dir_r & ~wdm[NPINS-1:0];
			else if (aw == `GP_OFS_DIRNOT)
				dir_nxt = dir_r ^ wdm[NPINS-1:0];
		end
		dir_nxt = dir_nxt & PRESENT_MASK;
	end

	// Output bits
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			out_r <= `GP_OUT_RESET;
		else
			out_r <= out_nxt;
	end

	// RULE10 RULE11 direction resets to all inputs
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			dir_r <= `GP_DIR_RESET;
		else
			dir_r <= dir_nxt;
	end

	// Mask register, byte lanes honoured
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mask_r <= `GP_MASK_RESET;
		else if (wr && (aw == `GP_OFS_MASK))
			mask_r <= ((mask_r & ~bmask[NPINS-1:0]) | wdm[NPINS-1:0]) & PRESENT_MASK;
	end

	// RULE8 read mux returns whole word; the master picks its lanes
	always_comb
	begin
		rd_nxt = '0;
		if (in_byte)
		begin
			for (int i = 0; i < 4; i++)
			begin
				// RULE1 RULE4 byte reads 0x01 or 0
				if ((int'(bsel) + i < NPINS) && state_w[int'(bsel) + i])
					rd_nxt[8*i +: 8] = `GP_BYTE_ONE;
			end
		end
		// RULE6 word reads all ones or zeros
		else if (in_word)
			rd_nxt = {32{state_w[wsel]}};
		else if (aw == `GP_OFS_DIR)
			rd_nxt[NPINS-1:0] = dir_r;
		else if (aw == `GP_OFS_MASK)
			rd_nxt[NPINS-1:0] = mask_r;
		else if (aw == `GP_OFS_PIN)
			rd_nxt[NPINS-1:0] = state_w;
		else if (aw == `GP_OFS_MPIN)
			rd_nxt[NPINS-1:0] = state_w & ~mask_r;
		else if (aw == `GP_OFS_SET)
			rd_nxt[NPINS-1:0] = out_r;
	end

	// APB phase tracking
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			phase_r <= ACC_IDLE;
		else
		begin
			unique case (phase_r)
				ACC_IDLE: if (psel && !penable) phase_r <= ACC_SETUP;
				ACC_SETUP: if (psel && penable) phase_r <= ACC_DONE;
				ACC_DONE: phase_r <= (psel && !penable) ? ACC_SETUP : ACC_IDLE;
			endcase
		end
	end

	// Registered answer; pready high one cycle after the first access cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			prdata <= '0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= acc;
			pslverr <= acc && !mapped;
			if (acc && !pwrite)
				prdata <= rd_nxt;
		end
	end

	// RULE21 drive pad only as GPIO output
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pad_out <= '0;
			pad_oe_n <= '1;
		end
		else
		begin
			pad_out <= out_r;
			pad_oe_n <= ~(dir_r & pin_gpio_sel & PRESENT_MASK);
		end
	end

	property p_dirset;
		@(posedge pclk) disable iff (!presetn)
		(wr && aw == `GP_OFS_DIRSET) |=> ((dir_r & $past(wdm[NPINS-1:0]) & PRESENT_MASK)
			== ($past(wdm[NPINS-1:0]) & PRESENT_MASK));
	endproperty
	a_dirset: assert property (p_dirset) else $error("direction set lost"); // RULE13

	property p_clr;
		@(posedge pclk) disable iff (!presetn)
		(wr && aw == `GP_OFS_CLR) |=> ((out_r & $past(wdm[NPINS-1:0])) == '0);
	endproperty
	a_clr: assert property (p_clr) else $error("clear left bits set"); // RULE19

	property p_tog;
		@(posedge pclk) disable iff (!presetn)
		(wr && aw == `GP_OFS_NOT) |=>
			(out_r == (($past(out_r) ^ $past(wdm[NPINS-1:0])) & PRESENT_MASK));
	endproperty
	a_tog: assert property (p_tog) else $error("toggle wrong"); // RULE20

	property p_mpin_keep;
		@(posedge pclk) disable iff (!presetn)
		(wr && aw == `GP_OFS_MPIN) |=> ((out_r & $past(mask_r)) == ($past(out_r) & $past(mask_r)));
	endproperty
	a_mpin_keep: assert property (p_mpin_keep) else $error("masked bit changed"); // RULE17

	property p_absent;
		@(posedge pclk) disable iff (!presetn)
		((out_r | dir_r | mask_r) & ~PRESENT_MASK) == '0;
	endproperty
	a_absent: assert property (p_absent) else $error("absent pin bit set"); // RULE14

	property p_oe;
		@(posedge pclk) disable iff (!presetn)
		!(dir_r[0] && pin_gpio_sel[0]) |=> pad_oe_n[0];
	endproperty
	a_oe: assert property (p_oe) else $error("pad driven while input"); // RULE21

	property p_word_rd;
		@(posedge pclk) disable iff (!presetn)
		(acc && !pwrite && in_word) |=> (prdata == '0 || prdata == '1);
	endproperty
	a_word_rd: assert property (p_word_rd) else $error("word pin read mixed"); // RULE6

	property p_byte_rd;
		@(posedge pclk) disable iff (!presetn)
		(acc && !pwrite && in_byte) |=> ((prdata & 32'hfefefefe) == '0);
	endproperty
	a_byte_rd: assert property (p_byte_rd) else $error("byte pin upper bits set"); // RULE4

	property p_ready;
		@(posedge pclk) disable iff (!presetn)
		(psel && !penable) ##1 (psel && penable) |=> pready;
	endproperty
	a_ready: assert property (p_ready) else $error("no answer"); // RULE8

	property p_pulse;
		@(posedge pclk) disable iff (!presetn)
		pready |=> !pready;
	endproperty
	a_pulse: assert property (p_pulse) else $error("answer stretched"); // RULE8

	property p_set;
		@(posedge pclk) disable iff (!presetn)
		(wr && aw == `GP_OFS_SET) |=> ((out_r & $past(wdm[NPINS-1:0]) & PRESENT_MASK)
			== ($past(wdm[NPINS-1:0]) & PRESENT_MASK));
	endproperty
	a_set: assert property (p_set) else $error("set lost a bit"); // RULE12

	property p_pin_wr;
		@(posedge pclk) disable iff (!presetn)
		(wr && aw == `GP_OFS_PIN && pstrb == 4'hf) |=>
			(out_r == ($past(pwdata[NPINS-1:0]) & PRESENT_MASK));
	endproperty
	a_pin_wr: assert property (p_pin_wr) else $error("whole port write wrong"); // RULE18

	property p_word_wr;
		@(posedge pclk) disable iff (!presetn)
		(wr && in_word && wsel == 5'h00 && pstrb == 4'hf && PRESENT_MASK[0]) |=>
			(out_r[0] == ($past(pwdata) != '0));
	endproperty
	a_word_wr: assert property (p_word_wr) else $error("word pin write wrong"); // RULE7

	property p_byte_wr;
		@(posedge pclk) disable iff (!presetn)
		(wr && in_byte && aw[4:2] == 3'h0 && pstrb[0] && PRESENT_MASK[0]) |=>
			(out_r[0] == $past(pwdata[0]));
	endproperty
	a_byte_wr: assert property (p_byte_wr) else $error("byte pin write wrong"); // RULE3

	property p_slverr;
		@(posedge pclk) disable iff (!presetn)
		(acc && !mapped) |=> (pslverr && pready);
	endproperty
	a_slverr: assert property (p_slverr) else $error("unmapped access not flagged"); // RULE9
endmodule

// file: hdl/gpio_port_params.svh
// Constants of the general-purpose I/O port register block.
// Assumes a 32-bit APB slave with byte strobes and a 10 MHz pclk.
// Summary of operation
// RULE1 - Byte pin register reads 0x01 when pin high, 0 when low.
// RULE2 - Pins in analog mode read zero through every pin-state register.
// RULE3 - Byte pin write loads the output bit from data bit 0.
// RULE4 - Byte pin bits 7:1 read zero; writes to them ignored.
// RULE5 - Halfword or word in byte range reaches two or four pins.
// RULE6 - Word pin register reads all zeros or all ones by pin.
// RULE7 - Word pin write clears output on zero value, else sets.
// RULE8 - Every register accepts byte, halfword and word accesses.
// RULE9 - Byte pins at offsets 0 to 17; word pins from word base.
// RULE10 - Direction bit 1 means output, 0 input; resets to zero.
// RULE11 - After reset every pin is an input.
// RULE12 - Set register reads output bits; writing ones sets them.
// RULE13 - Write-only direction set, clear and toggle registers.
// RULE14 - Pin six and missing pins read zero, ignore writes.
// RULE15 - Pin-level registers show sampled pin state after reset.
// RULE16 - Software enables the port clock before any access.
// RULE17 - Masked port register reaches only pins whose mask bit is 0.
// RULE18 - Whole-port register reads all pins, writes all, ignores mask.
// RULE19 - Ones written to clear register clear output bits.
// RULE20 - Ones written to toggle register invert output bits.
// RULE21 - Pad driven only when direction is output and pin is GPIO.
`ifndef GPIO_PORT_PARAMS_SVH
`define GPIO_PORT_PARAMS_SVH
`define GP_NPINS 18
`define GP_ABSENT_MASK 18'h00040
`define GP_BYTE_LAST 14'h0011
`define GP_WORD_BASE 14'h1000
`define GP_WORD_LAST 14'h1044
`define GP_OFS_DIR 14'h2000
`define GP_OFS_MASK 14'h2080
`define GP_OFS_PIN 14'h2100
`define GP_OFS_MPIN 14'h2180
`define GP_OFS_SET 14'h2200
`define GP_OFS_CLR 14'h2280
`define GP_OFS_NOT 14'h2300
`define GP_OFS_DIRSET 14'h2380
`define GP_OFS_DIRCLR 14'h2400
`define GP_OFS_DIRNOT 14'h2480
`define GP_DIR_RESET 18'h00000
`define GP_MASK_RESET 18'h00000
`define GP_OUT_RESET 18'h00000
`define GP_BYTE_ONE 8'h01
`endif

// file: hdl/gpio_port_pkg.sv
// Types shared by the port register block.
// Assumes the constants header is included alongside.
package gpio_port_pkg;
	typedef enum logic [1:0] {ACC_IDLE, ACC_SETUP, ACC_DONE} apb_phase_e;
	typedef logic [31:0] word_t;
endpackage

// file: sim/pad_model.sv
// Pad model for the port block: driven pads loop back as sensed levels.
// Assumes the bench supplies the level of every pin that is not driven.
`timescale 1ns/100ps
module pad_model
(
	input wire logic [17:0] ext_level, // Level of undriven pins
	input wire logic [17:0] pad_out, // Driven pad values
	input wire logic [17:0] pad_oe_n, // Low while the block drives
	output logic [17:0] pin_level // Sensed pad levels
);
	assign pin_level = (pad_out & ~pad_oe_n) | (ext_level & pad_oe_n);
endmodule

// file: sim/testbench.sv
// Self-checking bench for the port register block.
// Assumes the pad model closes the pin loop and APB as handed over.
`timescale 1ns/100ps
`include "gpio_port_params.svh"
module testbench
	import gpio_port_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [13:0] paddr = 14'h0000;
	word_t pwdata = 32'h00000000;
	logic [3:0] pstrb = 4'h0;
	logic [17:0] ext = 18'h3ffff;
	logic [17:0] ana = 18'h00000;
	logic [17:0] gsel = 18'h3ffff;
	word_t prdata;
	logic pready;
	logic pslverr;
	logic [17:0] lvl;
	logic [17:0] pout;
	logic [17:0] poe_n;
	int error_cnt = 0;
	int num_checks = 0;
	// Free-running 10 MHz clock
	always #50 pclk = ~pclk;
	gpio_port_pin_access uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pin_level(lvl), .pin_analog(ana), .pin_gpio_sel(gsel),
		.pad_out(pout), .pad_oe_n(poe_n));
	pad_model pm (.ext_level(ext), .pad_out(pout), .pad_oe_n(poe_n),
		.pin_level(lvl));
	task automatic chk(input string nm, input word_t seen, input word_t exp);
		num_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// One transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [13:0] a, input word_t d,
		input logic [3:0] s, output word_t r, output logic e);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
		begin
			error_cnt++;
			final_report();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [13:0] a, input word_t d);
		word_t r;
		logic e;
		apb(1'b1, a, d, 4'hf, r, e);
	endtask
	task automatic rd(input logic [13:0] a, input word_t exp);
		word_t r;
		logic e;
		apb(1'b0, a, 32'h00000000, 4'hf, r, e);
		chk($sformatf("addr %h", a), r, exp);
	endtask
	// Reset values and pin-level readback of all pins high
	task automatic t_reset();
		chk("pad_oe_n", {14'h0000, poe_n}, 32'h0003ffff);
		rd(`GP_OFS_DIR, 32'h00000000);
		rd(`GP_OFS_SET, 32'h00000000);
		rd(`GP_OFS_PIN, 32'h0003ffbf);
		rd(14'h0000, 32'h01010101);
		rd(14'h0004, 32'h01000101);
		rd(14'h0010, 32'h00000101);
		rd(`GP_WORD_LAST, 32'hffffffff);
		rd(14'h1018, 32'h00000000);
	endtask
	// Analog pin and a low pin in the byte, word and whole-port read views
	task automatic t_analog();
		ext <= 18'h3fffb;
		ana <= 18'h00002;
		repeat (3) @(posedge pclk);
		rd(`GP_OFS_PIN, 32'h0003ffb9);
		rd(14'h0000, 32'h01000001);
		rd(14'h1004, 32'h00000000);
		rd(14'h1008, 32'h00000000);
	endtask
	// Masked view on read and write, whole port written to zero while the mask is set
	task automatic t_mask();
		wr(`GP_OFS_MASK, 32'h0000ff00);
		rd(`GP_OFS_MASK, 32'h0000ff00);
		rd(`GP_OFS_MPIN, 32'h000300b9);
		wr(`GP_OFS_MPIN, 32'h0003ffff);
		rd(`GP_OFS_SET, 32'h000300bf);
		wr(`GP_OFS_PIN, 32'h00000000);
		rd(`GP_OFS_SET, 32'h00000000);
	endtask
	// Byte and word pin writes, lane strobes
	task automatic t_write();
		word_t r;
		logic e;
		wr(14'h0000, 32'hfe01fe01);
		rd(`GP_OFS_SET, 32'h00000005);
		apb(1'b1, 14'h0000, 32'h00000100, 4'b0010, r, e);
		rd(`GP_OFS_SET, 32'h00000007);
		wr(14'h1014, 32'h80000000);
		wr(`GP_WORD_BASE, 32'h00000000);
		rd(`GP_OFS_SET, 32'h00000026);
	endtask
	// Set, clear, toggle and an unmapped place
	task automatic t_port();
		word_t r;
		logic e;
		wr(`GP_OFS_SET, 32'h00000049);
		rd(`GP_OFS_SET, 32'h0000002f);
		wr(`GP_OFS_CLR, 32'h00000003);
		rd(`GP_OFS_CLR, 32'h00000000);
		rd(`GP_OFS_SET, 32'h0000002c);
		wr(`GP_OFS_NOT, 32'h00000030);
		rd(`GP_OFS_SET, 32'h0000001c);
		apb(1'b0, 14'h3000, 32'h00000000, 4'hf, r, e);
		chk("pslverr", {31'h0, e}, 32'h00000001);
	endtask
	// Direction aliases, pad enables and loopback through the pads
	task automatic t_dir();
		wr(`GP_OFS_DIRSET, 32'h0003ffff);
		rd(`GP_OFS_DIR, 32'h0003ffbf);
		wr(`GP_OFS_DIRCLR, 32'h00000f00);
		wr(`GP_OFS_DIRNOT, 32'h00000003);
		rd(`GP_OFS_DIR, 32'h0003f0bc);
		chk("pad_oe_n", {14'h0000, poe_n}, 32'h00000f43);
		chk("pad_out", {14'h0000, pout}, 32'h0000001c);
		gsel <= 18'h3fffb;
		repeat (4) @(posedge pclk);
		chk("pad_oe_n", {14'h0000, poe_n}, 32'h00000f47);
		rd(`GP_OFS_PIN, 32'h00000f19);
	endtask
	// Main sequence; the clock runs before the first access
	initial
	begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		t_reset();
		t_analog();
		t_mask();
		t_write();
		t_port();
		t_dir();
		final_report();
	end
endmodule
